// ===== radio_irq_defines.svh
// Offsets, bit positions and reset values of the event flag block.
// Included by the package and by the design module.
`ifndef RADIO_IRQ_DEFINES_SVH
`define RADIO_IRQ_DEFINES_SVH

`define ADDR_STATUS1 6'h00
`define ADDR_STATUS2 6'h01
`define ADDR_MASK1 6'h02
`define ADDR_MASK2 6'h03
`define ADDR_ONE 6'h01

`define BIT_RX 7
`define BIT_TX 6
`define BIT_RETRY 5
`define BIT_SUPPLY 2
`define BIT_STANDBY 1
`define BIT_POWERDOWN 0
`define BIT_RESET 1
`define BIT_CAL 0

`define STATUS1_VALID 8'he7
`define STATUS2_VALID 8'h03
`define MASK2_VALID 8'h01
`define FLAGS_RST 8'h00
`define BYTE_ZERO 8'h00

`define CMD_WRITE_BIT 7
`define CMD_ADDR_HI 5
`define BIT_CNT_ZERO 3'h0
`define BIT_CNT_ONE 3'h1
`define BIT_CNT_LAST 3'h7

`define PIN_SCK 0
`define PIN_SDI 1
`define PIN_CSN 2
`define PIN_IDLE 3'h4

`endif

// ===== radio_irq_pkg.sv
// Types shared by the event flag block.
// Assumes the defines header is on the include path.
`include "radio_irq_defines.svh"

package radio_irq_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [5:0] addr_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CMD = 2'b01,
      PH_DATA = 2'b10
   } phase_e;

   // One-cycle event pulses from the radio and power logic
   typedef struct packed {
      logic packet_received;
      logic packet_sent;
      logic retry_limit;
      logic supply_check_done;
      logic supply_above_ref;
      logic standby_exit;
      logic powerdown_exit;
      logic reset_occurred;
      logic calibration_done;
   } event_s;

endpackage

// ===== radio_interrupt_flags.sv
// Event status and mask registers with the interrupt pin, reached
// through the byte-based serial control port.
// Assumes event pulses come from logic on sys_clk; serial pins are
// asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "radio_irq_defines.svh"

// What this block does
// RULE1: Writing one clears a status bit
// RULE2: Primary bit 7 flags packet received
// RULE3: Primary bit 6 flags packet sent
// RULE4: Primary bit 5 flags retry limit exceeded
// RULE5: Bit 2 flags supply check finished
// RULE6: Low-only option: flag only below reference
// RULE7: Primary bit 1 flags standby exit
// RULE8: Primary bit 0 flags power-down exit
// RULE9: Secondary bit 1 flags reset, always enabled
// RULE10: Secondary bit 0 flags calibration done
// RULE11: Primary mask bits route matching flags
// RULE12: Secondary mask bit 0 routes calibration flag
// RULE13: Host keeps primary mask bits 4:3 zero
// RULE14: Host writes ones to status bits 4:3
// RULE15: Unmapped addresses do nothing
// RULE16: Interrupt high when flagged and unmasked
// RULE17: Writing zero keeps a status bit
// RULE18: Only internal events set flags
// RULE19: Primary status shifted out every transaction
// RULE20: Flags and masks zero after reset
// RULE21: Event beats a simultaneous clear
module radio_interrupt_flags (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Serial control port
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   // Internal events and supply check option
   input radio_irq_pkg::event_s events,
   input wire logic flag_only_on_low_supply,
   // Interrupt to host
   output logic irq
);
   import radio_irq_pkg::*;

   logic [2:0] pin_m_q, pin_m_d, pin_s_q, pin_s_d, pin_p_q, pin_p_d;
   phase_e phase_q, phase_d;
   logic [2:0] cnt_q, cnt_d;
   byte_t rx_q, rx_d, tx_q, tx_d;
   addr_t addr_q, addr_d;
   logic write_q, write_d;
   logic sdo_q, sdo_d, oe_n_q, oe_n_d;
   byte_t st1_q, st1_d, st2_q, st2_d, m1_q, m1_d, m2_q, m2_d;
   logic irq_q, irq_d;
   logic csn_low, csn_fall, sck_rise, sck_fall;
   logic wr_en;
   addr_t wr_addr;
   byte_t wr_data, in_byte, set1, set2, clr1, clr2;
   byte_t status_now;

   // Reserved bits read as zero except in the primary mask; unmapped addresses read zero
   function automatic byte_t reg_read(input addr_t a);
      case (a)
         `ADDR_STATUS1: reg_read = st1_q & `STATUS1_VALID;
         `ADDR_STATUS2: reg_read = st2_q & `STATUS2_VALID;
         `ADDR_MASK1: reg_read = m1_q;
         `ADDR_MASK2: reg_read = m2_q & `MASK2_VALID;
         default: reg_read = `BYTE_ZERO; // RULE15
      endcase
   endfunction

   // Pin synchronisers, then one stage for edge detection
   always_comb begin
      pin_m_d = {spi_cs_n, spi_mosi, spi_sck};
      pin_s_d = pin_m_q;
      pin_p_d = pin_s_q;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_m_q <= `PIN_IDLE;
         pin_s_q <= `PIN_IDLE;
         pin_p_q <= `PIN_IDLE;
      end else begin
         pin_m_q <= pin_m_d;
         pin_s_q <= pin_s_d;
         pin_p_q <= pin_p_d;
      end
   end

   assign csn_low = !pin_s_q[`PIN_CSN];
   assign csn_fall = csn_low && pin_p_q[`PIN_CSN];
   assign sck_rise = csn_low && pin_s_q[`PIN_SCK] && !pin_p_q[`PIN_SCK];
   assign sck_fall = csn_low && !pin_s_q[`PIN_SCK] && pin_p_q[`PIN_SCK];
   assign in_byte = {rx_q[6:0], pin_s_q[`PIN_SDI]};

   // Serial byte engine: command byte, then auto-incrementing data
   always_comb begin
      phase_d = phase_q;
      cnt_d = cnt_q;
      rx_d = rx_q;
      tx_d = tx_q;
      addr_d = addr_q;
      write_d = write_q;
      sdo_d = sdo_q;
      oe_n_d = !csn_low;
      wr_en = 1'b0;
      wr_addr = addr_q;
      wr_data = in_byte;
      status_now = reg_read(`ADDR_STATUS1);
      if (!csn_low) begin
         // Partial bytes are dropped here
         phase_d = PH_IDLE;
         cnt_d = `BIT_CNT_ZERO;
      end else if (csn_fall) begin
         tx_d = {status_now[6:0], 1'b0}; // RULE19
         sdo_d = status_now[7]; // RULE19
         phase_d = PH_CMD;
         cnt_d = `BIT_CNT_ZERO;
      end else if (sck_rise) begin
         rx_d = in_byte;
         cnt_d = cnt_q + `BIT_CNT_ONE;
         if (cnt_q == `BIT_CNT_LAST) begin
            case (phase_q)
               PH_CMD: begin
                  write_d = in_byte[`CMD_WRITE_BIT];
                  addr_d = in_byte[`CMD_ADDR_HI:0];
                  tx_d = reg_read(in_byte[`CMD_ADDR_HI:0]);
                  phase_d = PH_DATA;
               end
               PH_DATA: begin
                  wr_en = write_q;
                  addr_d = addr_q + `ADDR_ONE;
                  tx_d = reg_read(addr_q + `ADDR_ONE);
               end
               default: begin
                  phase_d = PH_IDLE;
               end
            endcase
         end
      end else if (sck_fall) begin
         sdo_d = tx_q[7];
         tx_d = {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase_q <= PH_IDLE;
         cnt_q <= `BIT_CNT_ZERO;
         rx_q <= `BYTE_ZERO;
         tx_q <= `BYTE_ZERO;
         addr_q <= `ADDR_STATUS1;
         write_q <= 1'b0;
         sdo_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         addr_q <= addr_d;
         write_q <= write_d;
         sdo_q <= sdo_d;
         oe_n_q <= oe_n_d;
      end
   end

   // Event flags, masks and interrupt
   always_comb begin
      set1 = `BYTE_ZERO;
      set2 = `BYTE_ZERO;
      set1[`BIT_RX] = events.packet_received; // RULE2
      set1[`BIT_TX] = events.packet_sent; // RULE3
      set1[`BIT_RETRY] = events.retry_limit; // RULE4
      set1[`BIT_SUPPLY] = events.supply_check_done &&
         (!flag_only_on_low_supply || !events.supply_above_ref); // RULE5 RULE6
      set1[`BIT_STANDBY] = events.standby_exit; // RULE7
      set1[`BIT_POWERDOWN] = events.powerdown_exit; // RULE8
      set2[`BIT_RESET] = events.reset_occurred; // RULE9
      set2[`BIT_CAL] = events.calibration_done; // RULE10
      clr1 = (wr_en && wr_addr == `ADDR_STATUS1) ? wr_data : `BYTE_ZERO;
      clr2 = (wr_en && wr_addr == `ADDR_STATUS2) ? wr_data : `BYTE_ZERO;
      // Set wins over clear; zeros keep the bit
      st1_d = ((st1_q & ~clr1) | set1) & `STATUS1_VALID; // RULE1 RULE17 RULE21
      st2_d = ((st2_q & ~clr2) | set2) & `STATUS2_VALID; // RULE1 RULE18 RULE21
      m1_d = (wr_en && wr_addr == `ADDR_MASK1) ? wr_data : m1_q;
      m2_d = (wr_en && wr_addr == `ADDR_MASK2) ?
         (wr_data & `MASK2_VALID) : m2_q; // RULE12
      irq_d = |(st1_q & m1_q & `STATUS1_VALID) || // RULE11 RULE16
         st2_q[`BIT_RESET] || // RULE9
         (st2_q[`BIT_CAL] && m2_q[`BIT_CAL]); // RULE12
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st1_q <= `FLAGS_RST; // RULE20
         st2_q <= `FLAGS_RST;
         m1_q <= `FLAGS_RST;
         m2_q <= `FLAGS_RST;
         irq_q <= 1'b0;
      end else begin
         st1_q <= st1_d;
         st2_q <= st2_d;
         m1_q <= m1_d;
         m2_q <= m2_d;
         irq_q <= irq_d;
      end
   end

   assign spi_miso = sdo_q;
   assign spi_miso_oe_n = oe_n_q;
   assign irq = irq_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_CLEAR_ONE: assert property ( // RULE1
      wr_en && wr_addr == `ADDR_STATUS1 && wr_data[`BIT_RX] &&
      !events.packet_received |=> !st1_q[`BIT_RX])
      else $error("status bit not cleared by write of one");
   AST_RX_SET: assert property ( // RULE2
      events.packet_received |=> st1_q[`BIT_RX] ##1
      (irq_q || !$past(m1_q[`BIT_RX])))
      else $error("packet received flag not set");
   AST_TX_SET: assert property ( // RULE3
      events.packet_sent |=> st1_q[`BIT_TX])
      else $error("packet sent flag not set");
   AST_RETRY_SET: assert property ( // RULE4
      events.retry_limit |=> st1_q[`BIT_RETRY])
      else $error("retry limit flag not set");
   AST_SUPPLY_DONE: assert property ( // RULE5
      events.supply_check_done && !flag_only_on_low_supply
      |=> st1_q[`BIT_SUPPLY])
      else $error("supply check flag not set");
   AST_SUPPLY_HIGH: assert property ( // RULE6
      events.supply_check_done && flag_only_on_low_supply &&
      events.supply_above_ref && !st1_q[`BIT_SUPPLY] |=> !st1_q[`BIT_SUPPLY])
      else $error("supply flag set although supply above reference");
   AST_STANDBY_SET: assert property ( // RULE7
      events.standby_exit |=> st1_q[`BIT_STANDBY])
      else $error("standby exit flag not set");
   AST_PD_SET: assert property ( // RULE8
      events.powerdown_exit |=> st1_q[`BIT_POWERDOWN])
      else $error("power-down exit flag not set");
   AST_RESET_IRQ: assert property ( // RULE9
      events.reset_occurred |-> ##2 irq_q)
      else $error("reset flag did not raise interrupt");
   AST_CAL_SET: assert property ( // RULE10
      events.calibration_done |=> st2_q[`BIT_CAL])
      else $error("calibration flag not set");
   AST_RESET_SET: assert property ( // RULE9
      events.reset_occurred |=> st2_q[`BIT_RESET])
      else $error("reset flag not set");
   AST_CLEAR_TWO: assert property ( // RULE1
      wr_en && wr_addr == `ADDR_STATUS2 && wr_data[`BIT_RESET] &&
      !events.reset_occurred |=> !st2_q[`BIT_RESET])
      else $error("secondary status bit not cleared by write of one");
   AST_SUPPLY_LOW: assert property ( // RULE6
      events.supply_check_done && flag_only_on_low_supply &&
      !events.supply_above_ref |=> st1_q[`BIT_SUPPLY])
      else $error("supply flag not set although supply low");
   AST_MASK_ROUTE: assert property ( // RULE11
      |(st1_q & m1_q & `STATUS1_VALID) |=> irq_q)
      else $error("unmasked flag did not raise interrupt");
   AST_CAL_ROUTE: assert property ( // RULE12
      !st2_q[`BIT_RESET] && (st1_q & m1_q & `STATUS1_VALID) == `BYTE_ZERO
      && !(st2_q[`BIT_CAL] && m2_q[`BIT_CAL]) |=> !irq_q)
      else $error("interrupt raised with nothing routed");
   AST_UNMAPPED: assert property ( // RULE15
      wr_en && wr_addr > `ADDR_MASK2 |=> $stable(m1_q) && $stable(m2_q))
      else $error("write to unmapped address changed a mask");
   AST_IRQ_LEVEL: assert property ( // RULE16
      irq_q |-> ($past(st1_q) & $past(m1_q) & `STATUS1_VALID) != `FLAGS_RST
      || $past(st2_q[`BIT_RESET])
      || ($past(st2_q[`BIT_CAL]) && $past(m2_q[`BIT_CAL])))
      else $error("interrupt high without cause");
   AST_ZERO_KEEPS: assert property ( // RULE17
      wr_en && wr_addr == `ADDR_STATUS1 && !wr_data[`BIT_TX] &&
      st1_q[`BIT_TX] |=> st1_q[`BIT_TX])
      else $error("writing zero changed a status bit");
   AST_NO_HOST_SET: assert property ( // RULE18
      !events.packet_received |=> !$rose(st1_q[`BIT_RX]))
      else $error("flag rose without event");
   AST_STATUS_OUT: assert property ( // RULE19
      csn_fall |=> sdo_q == $past(st1_q[`BIT_RX]) && !oe_n_q)
      else $error("status byte not presented at select");
   AST_AFTER_RESET: assert property ( // RULE20
      $past(rst) |-> !irq_q && st1_q == `FLAGS_RST && m1_q == `FLAGS_RST)
      else $error("state not cleared by reset");
   AST_SET_WINS: assert property ( // RULE21
      events.packet_sent && wr_en && wr_addr == `ADDR_STATUS1
      |=> st1_q[`BIT_TX])
      else $error("event lost against clear");

   COV_READ: cover property (phase_q == PH_DATA && !write_q && sck_fall);
   COV_WRITE_CLEAR: cover property (wr_en && wr_addr == `ADDR_STATUS1);
   COV_IRQ: cover property (!irq_q ##1 irq_q);
   COV_MASK_WRITE: cover property (wr_en && wr_addr == `ADDR_MASK1);
   COV_SET_WINS: cover property (events.packet_sent && wr_en &&
      wr_addr == `ADDR_STATUS1);

endmodule

// ===== spi_host.sv
// Host controller model: drives the serial control port.
// Assumes the design's serial pins and sys_clk; inputs change at fall.
`timescale 1ns/1ps

module spi_host (
   // Clock
   input wire logic sys_clk,
   // Serial lines
   input wire logic miso,
   output logic cs_n,
   output logic sck,
   output logic mosi
);
   import radio_irq_pkg::*;

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end

   // Command plus one data byte; returns status and data bytes
   task automatic xfer(input byte_t cmd, input byte_t din,
                       output byte_t st, output byte_t dout);
      logic [15:0] sh;
      logic [15:0] got;
      byte_t d;
      d = din;
      if (cmd[7] && cmd[5:0] == 6'h02) d = d & 8'he7;
      if (cmd[7] && cmd[5:0] == 6'h00) d = d | 8'h18;
      sh = {cmd, d};
      @(negedge sys_clk);
      cs_n <= 1'b0;
      repeat (6) @(negedge sys_clk);
      for (int i = 15; i >= 0; i--) begin
         mosi <= sh[i];
         repeat (6) @(negedge sys_clk);
         got[i] = miso;
         sck <= 1'b1;
         repeat (6) @(negedge sys_clk);
         sck <= 1'b0;
      end
      repeat (6) @(negedge sys_clk);
      cs_n <= 1'b1;
      // Idle line shows no stale data
      mosi <= ~mosi;
      repeat (6) @(negedge sys_clk);
      st = got[15:8];
      dout = got[7:0];
   endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the event flag block.
// Assumes the design, its package and the host model are compiled.
`timescale 1ns/1ps
`include "radio_irq_defines.svh"

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   fail_count++; $display("unexpected at %0t: got %h expected %h", \
   $time, g, e); end end

module tb_top;
   import radio_irq_pkg::*;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, sck, mosi, miso, oe_n, irq;
   logic low_only = 1'b0;
   event_s events = '0;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   byte_t st, rd, v;
   event_s ev_tab [6] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h008, 9'h004};
   byte_t st_tab [6] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h02, 8'h01};

   always #20 sys_clk = ~sys_clk;

   radio_interrupt_flags radio_interrupt_flags_inst (
      .sys_clk(sys_clk), .rst(rst), .spi_cs_n(cs_n), .spi_sck(sck),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(oe_n),
      .events(events), .flag_only_on_low_supply(low_only), .irq(irq));

   spi_host spi_host_inst (
      .sys_clk(sys_clk), .miso(miso), .cs_n(cs_n), .sck(sck),
      .mosi(mosi));

   task automatic rd_reg(input addr_t a, output byte_t val);
      spi_host_inst.xfer({2'b00, a}, 8'h00, st, val);
   endtask

   task automatic wr_reg(input addr_t a, input byte_t val);
      spi_host_inst.xfer({2'b10, a}, val, st, rd);
   endtask

   task automatic pulse(input event_s e);
      @(negedge sys_clk);
      events <= e;
      @(negedge sys_clk);
      events <= '0;
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic results;
      $display("mismatches %0d checks %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         results();
      end
   end

   initial begin
      repeat (12) @(negedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK(irq, 1'b0)
      `CHK(oe_n, 1'b1)
      for (int a = 0; a < 4; a++) begin
         rd_reg(6'(a), v);
         `CHK(v, 8'h00)
      end
      wr_reg(6'h04, 8'hff);
      rd_reg(6'h04, v);
      `CHK(v, 8'h00)
      wr_reg(6'h3f, 8'hff);
      rd_reg(6'h3f, v);
      `CHK(v, 8'h00)
      for (int i = 0; i < 6; i++) begin
         pulse(ev_tab[i]);
         rd_reg(`ADDR_STATUS1, v);
         `CHK(st, st_tab[i])
         `CHK(v, st_tab[i])
         `CHK(irq, 1'b0)
         wr_reg(`ADDR_MASK1, st_tab[i]);
         `CHK(irq, 1'b1)
         wr_reg(`ADDR_STATUS1, 8'h00);
         rd_reg(`ADDR_STATUS1, v);
         `CHK(v, st_tab[i])
         wr_reg(`ADDR_STATUS1, 8'hff);
         rd_reg(`ADDR_STATUS1, v);
         `CHK(v, 8'h00)
         `CHK(irq, 1'b0)
         wr_reg(`ADDR_MASK1, 8'h00);
         `CHK(rd, st_tab[i])
      end
      pulse(9'h1ec);
      wr_reg(`ADDR_STATUS1, 8'h80);
      rd_reg(`ADDR_STATUS1, v);
      `CHK(v, 8'h67)
      wr_reg(`ADDR_STATUS1, 8'hff);
      pulse(9'h030);
      rd_reg(`ADDR_STATUS1, v);
      `CHK(v, 8'h04)
      wr_reg(`ADDR_STATUS1, 8'hff);
      low_only <= 1'b1;
      pulse(9'h030);
      rd_reg(`ADDR_STATUS1, v);
      `CHK(v, 8'h00)
      pulse(9'h020);
      rd_reg(`ADDR_STATUS1, v);
      `CHK(v, 8'h04)
      wr_reg(`ADDR_STATUS1, 8'hff);
      low_only <= 1'b0;
      pulse(9'h002);
      `CHK(irq, 1'b1)
      rd_reg(`ADDR_STATUS2, v);
      `CHK(v, 8'h02)
      wr_reg(`ADDR_STATUS2, 8'hff);
      rd_reg(`ADDR_STATUS2, v);
      `CHK(v, 8'h00)
      `CHK(irq, 1'b0)
      pulse(9'h001);
      rd_reg(`ADDR_STATUS2, v);
      `CHK(v, 8'h01)
      `CHK(irq, 1'b0)
      wr_reg(`ADDR_MASK2, 8'hff);
      `CHK(irq, 1'b1)
      rd_reg(`ADDR_MASK2, v);
      `CHK(v, 8'h01)
      wr_reg(`ADDR_STATUS2, 8'h01);
      `CHK(irq, 1'b0)
      wr_reg(`ADDR_MASK2, 8'h00);
      // Event lands in the cycle the clear is applied
      fork
         wr_reg(`ADDR_STATUS1, 8'hff);
         begin
            wait (radio_interrupt_flags_inst.wr_en);
            @(negedge sys_clk);
            events <= 9'h080;
            @(negedge sys_clk);
            events <= '0;
         end
      join
      rd_reg(`ADDR_STATUS1, v);
      `CHK(v, 8'h40)
      wr_reg(`ADDR_MASK1, 8'h40);
      `CHK(irq, 1'b1)
      // Second reset with a flag set and unmasked
      rst <= 1'b1;
      repeat (2) @(negedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK(irq, 1'b0)
      rd_reg(`ADDR_STATUS1, v);
      `CHK(v, 8'h00)
      rd_reg(`ADDR_MASK1, v);
      `CHK(v, 8'h00)
      results();
   end
endmodule
